// >>> hdl/agm_pkg.sv
// Purpose: Shared constants and types of the amplifier gain and mode control
// Assumes: Registers are reached over the two-wire serial pins only
// Notes:   Register indices are the pointer values the host writes
package agm_pkg;

  // ==========================================================
  // Register indices, as sent in the pointer byte
  localparam logic [7:0] IDX_LEFT_BRIDGED  = 8'h00;
  localparam logic [7:0] IDX_RIGHT_BRIDGED = 8'h01;
  localparam logic [7:0] IDX_LEFT_SINGLE_ENDED_GAIN       = 8'h02;
  localparam logic [7:0] IDX_RIGHT_SINGLE_ENDED_GAIN      = 8'h03;
  localparam logic [7:0] IDX_CTRL          = 8'h04;
  localparam logic [7:0] IDX_STATUS        = 8'h05;
  localparam logic [7:0] IDX_GAIN_COUNT    = 8'h04;

  // ==========================================================
  // Field positions and reset values
  localparam int         GAIN_BITS          = 6;
  localparam int         CTRL_CFG_OVERRIDE  = 0;
  localparam int         CTRL_CFG_SE        = 1;
  localparam int         CTRL_BEEP_ENABLE   = 2;
  localparam logic [7:0] GAIN_RESET_BRIDGED = 8'h00;
  localparam logic [7:0] GAIN_RESET_SE      = 8'h00;
  localparam logic [7:0] CTRL_RESET         = 8'h00;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // ==========================================================
  // Fixed upper part of the slave address, value arbitrary
  localparam logic [4:0] SLAVE_ADDR_HIGH = 5'h15;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam int         SYNC_WIDTH      = 8;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [1:0]           mute;
    logic [GAIN_BITS-1:0] gain;
  } agm_chan_s;

  typedef struct packed {
    logic scl;
    logic sda;
    logic outputConfigSelect;
    logic shutdownN;
    logic beepModeEnable;
    logic beepInput;
    logic slaveAddrPinBit1;
    logic slaveAddrPinBit0;
  } agm_pins_s;

  // Reset level of the sampled pins: bus lines idle high, no false edge
  localparam agm_pins_s PINS_RESET = '{scl: 1'b1, sda: 1'b1, default: 1'b0};

  typedef enum logic [6:0] {
    S_IDLE    = 7'b0000001,
    S_ADDR    = 7'b0000010,
    S_ACK_ADR = 7'b0000100,
    S_WRITE   = 7'b0001000,
    S_ACK_WR  = 7'b0010000,
    S_READ    = 7'b0100000,
    S_ACK_RD  = 7'b1000000
  } agm_state_e;

endpackage

// >>> hdl/agm_sync.sv
// Purpose: Two-stage synchroniser for the pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module agm_sync (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire agm_pkg::agm_pins_s pinIn,
  output agm_pkg::agm_pins_s      pinOut
);
  import agm_pkg::*;

  agm_pins_s stage1;

  // Two flip-flops per pin
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage1 <= PINS_RESET;
      pinOut <= PINS_RESET;
    end else begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end
endmodule

// >>> hdl/amp_gain_mode_control.sv
// Purpose: Gain registers, mode select, shutdown and beep logic with a
//          two-wire serial slave for register access
// Assumes: All pins are asynchronous; the serial clock is sampled
// Notes:   Single-ended path has a fixed extra -6 dB in the analog stage
`timescale 1ns/100ps

module amp_gain_mode_control (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire agm_pkg::agm_pins_s pins,
  output logic                    sdaOut,
  output logic                    sdaOe,
  output logic                    singleEndedMode,
  output logic                    headphoneSelect,
  output logic                    ampEnable,
  output logic                    beepActive,
  output logic                    leftNegativeOutOe,
  output logic                    rightNegativeOutOe,
  output agm_pkg::agm_chan_s      leftChan,
  output agm_pkg::agm_chan_s      rightChan
);
  import agm_pkg::*;

  // ==========================================================
  // Pin sampling
  agm_pins_s  pinS;
  logic       sclPrev;
  logic       sdaPrev;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic [6:0] slaveAddr;

  agm_sync u_sync (
    .clock  (clock),
    .nrst   (nrst),
    .pinIn  (pins),
    .pinOut (pinS)
  );

  // Edge history of the sampled bus lines
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= pinS.scl;
      sdaPrev <= pinS.sda;
    end
  end

  // Bus events and the address this slave answers to
  assign sclRise   = pinS.scl & ~sclPrev;
  assign sclFall   = ~pinS.scl & sclPrev;
  assign startSeen = pinS.scl & sclPrev & sdaPrev & ~pinS.sda;
  assign stopSeen  = pinS.scl & sclPrev & ~sdaPrev & pinS.sda;
  assign slaveAddr = {SLAVE_ADDR_HIGH, pinS.slaveAddrPinBit1,
                      pinS.slaveAddrPinBit0};

  // ==========================================================
  // Serial slave and register file
  agm_state_e state;
  agm_state_e next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] txByte;
  logic [7:0] next_txByte;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic       readNotWrite;
  logic       next_readNotWrite;
  logic       firstByte;
  logic       next_firstByte;
  logic       next_sdaOe;
  logic [7:0] gainReg [4];
  logic [7:0] next_gainReg [4];
  logic [7:0] ctrlReg;
  logic [7:0] next_ctrlReg;
  logic [7:0] rdByte;

  // Read data for a pointer; unmapped pointers read zero
  function automatic logic [7:0] regRead(input logic [7:0] idx);
    logic [7:0] val;
    val = READ_UNMAPPED;
    if (idx < IDX_GAIN_COUNT) begin
      val = gainReg[idx[1:0]];
    end else if (idx == IDX_CTRL) begin
      val = ctrlReg;
    end else if (idx == IDX_STATUS) begin
      val = {3'h0, pinS.slaveAddrPinBit1, pinS.slaveAddrPinBit0,
             ~ampEnable, beepActive, singleEndedMode};
    end
    return val;
  endfunction

  // Byte-level slave: address, pointer, then auto-incrementing data
  always_comb begin
    next_state        = state;
    next_bitCnt       = bitCnt;
    next_shift        = shift;
    next_txByte       = txByte;
    next_ptr          = ptr;
    next_readNotWrite = readNotWrite;
    next_firstByte    = firstByte;
    next_sdaOe        = sdaOe;
    next_gainReg      = gainReg;
    next_ctrlReg      = ctrlReg;
    rdByte            = regRead(ptr);
    if (startSeen) begin
      next_state  = S_ADDR;
      next_bitCnt = 4'h0;
      next_sdaOe  = 1'b0;
    end else if (stopSeen) begin
      next_state = S_IDLE;
      next_sdaOe = 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          next_sdaOe = 1'b0;
        end
        S_ADDR, S_WRITE: begin
          if (sclRise) begin
            next_shift  = {shift[6:0], pinS.sda};
            next_bitCnt = bitCnt + 4'h1;
          end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
            next_bitCnt = 4'h0;
            if (state == S_ADDR) begin
              if (shift[7:1] == slaveAddr) begin
                next_state        = S_ACK_ADR;
                next_sdaOe        = 1'b1;
                next_readNotWrite = shift[0];
              end else begin
                next_state = S_IDLE;
              end
            end else begin
              next_state = S_ACK_WR;
              next_sdaOe = 1'b1;
              next_firstByte = 1'b0;
              if (firstByte) begin
                next_ptr = shift;
              end else begin
                next_ptr = ptr + 8'h1;
                if (ptr < IDX_GAIN_COUNT) begin
                  next_gainReg[ptr[1:0]] = shift;
                end else if (ptr == IDX_CTRL) begin
                  next_ctrlReg = shift;
                end
              end
            end
          end
        end
        S_ACK_ADR: begin
          if (sclFall) begin
            if (readNotWrite) begin
              next_state  = S_READ;
              next_txByte = rdByte;
              next_sdaOe  = ~rdByte[7];
              next_ptr    = ptr + 8'h1;
            end else begin
              next_state     = S_WRITE;
              next_sdaOe     = 1'b0;
              next_firstByte = 1'b1;
            end
          end
        end
        S_ACK_WR: begin
          if (sclFall) begin
            next_state = S_WRITE;
            next_sdaOe = 1'b0;
          end
        end
        S_READ: begin
          if (sclFall) begin
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt + 4'h1 == BITS_PER_BYTE) begin
              next_state = S_ACK_RD;
              next_sdaOe = 1'b0;
            end else begin
              next_txByte = {txByte[6:0], 1'b0};
              next_sdaOe  = ~txByte[6];
            end
          end
        end
        S_ACK_RD: begin
          if (sclRise) begin
            next_readNotWrite = ~pinS.sda;
          end else if (sclFall) begin
            next_bitCnt = 4'h0;
            if (readNotWrite) begin
              next_state  = S_READ;
              next_txByte = rdByte;
              next_sdaOe  = ~rdByte[7];
              next_ptr    = ptr + 8'h1;
            end else begin
              next_state = S_IDLE;
            end
          end
        end
        default: begin
          next_state = S_IDLE;
          next_sdaOe = 1'b0;
        end
      endcase
    end
  end

  // Slave and register state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state        <= S_IDLE;
      bitCnt       <= 4'h0;
      shift        <= 8'h00;
      txByte       <= 8'h00;
      ptr          <= 8'h00;
      readNotWrite <= 1'b0;
      firstByte    <= 1'b0;
      sdaOe        <= 1'b0;
      sdaOut       <= 1'b0;
      gainReg[IDX_LEFT_BRIDGED[1:0]]  <= GAIN_RESET_BRIDGED;
      gainReg[IDX_RIGHT_BRIDGED[1:0]] <= GAIN_RESET_BRIDGED;
      gainReg[IDX_LEFT_SINGLE_ENDED_GAIN[1:0]]       <= GAIN_RESET_SE;
      gainReg[IDX_RIGHT_SINGLE_ENDED_GAIN[1:0]]      <= GAIN_RESET_SE;
      ctrlReg      <= CTRL_RESET;
    end else begin
      state        <= next_state;
      bitCnt       <= next_bitCnt;
      shift        <= next_shift;
      txByte       <= next_txByte;
      ptr          <= next_ptr;
      readNotWrite <= next_readNotWrite;
      firstByte    <= next_firstByte;
      sdaOe        <= next_sdaOe;
      sdaOut       <= 1'b0;
      gainReg      <= next_gainReg;
      ctrlReg      <= next_ctrlReg;
    end
  end

  // ==========================================================
  // Mode, shutdown, beep and channel outputs
  logic      next_singleEnded;
  logic      next_ampEnable;
  logic      next_beepActive;
  agm_chan_s next_leftChan;
  agm_chan_s next_rightChan;

  // Mode from pin or register; channels from the matching gain register
  always_comb begin
    if (ctrlReg[CTRL_CFG_OVERRIDE]) begin
      next_singleEnded = ctrlReg[CTRL_CFG_SE];
    end else begin
      next_singleEnded = pinS.outputConfigSelect;
    end
    next_ampEnable  = pinS.shutdownN;
    next_beepActive = pinS.beepInput | pinS.beepModeEnable
                      | ctrlReg[CTRL_BEEP_ENABLE];
    if (next_singleEnded) begin
      next_leftChan  = gainReg[IDX_LEFT_SINGLE_ENDED_GAIN[1:0]];
      next_rightChan = gainReg[IDX_RIGHT_SINGLE_ENDED_GAIN[1:0]];
    end else begin
      next_leftChan  = gainReg[IDX_LEFT_BRIDGED[1:0]];
      next_rightChan = gainReg[IDX_RIGHT_BRIDGED[1:0]];
    end
  end

  // Registered analog controls
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      singleEndedMode    <= 1'b0;
      headphoneSelect    <= 1'b0;
      ampEnable          <= 1'b0;
      beepActive         <= 1'b0;
      leftNegativeOutOe  <= 1'b0;
      rightNegativeOutOe <= 1'b0;
      leftChan           <= GAIN_RESET_BRIDGED;
      rightChan          <= GAIN_RESET_BRIDGED;
    end else begin
      singleEndedMode    <= next_singleEnded;
      headphoneSelect    <= next_singleEnded;
      ampEnable          <= next_ampEnable;
      beepActive         <= next_beepActive;
      leftNegativeOutOe  <= ~next_singleEnded;
      rightNegativeOutOe <= ~next_singleEnded;
      leftChan           <= next_leftChan;
      rightChan          <= next_rightChan;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence pinModeSe;
    !ctrlReg[CTRL_CFG_OVERRIDE] && pinS.outputConfigSelect;
  endsequence

  sequence byteWrittenLeftSe;
    state == S_WRITE && sclFall && bitCnt == BITS_PER_BYTE && !firstByte
      && ptr == IDX_LEFT_SINGLE_ENDED_GAIN && !startSeen && !stopSeen;
  endsequence

  a_pin_high_se: assert property (pinModeSe |=>
    singleEndedMode && headphoneSelect)
    else $error("Select pin high did not give single-ended mode");

  a_pin_low_btl: assert property (
    !ctrlReg[CTRL_CFG_OVERRIDE] && !pinS.outputConfigSelect
    |=> !singleEndedMode && !headphoneSelect)
    else $error("Select pin low did not give bridged mode");

  a_host_mode_set: assert property (ctrlReg[CTRL_CFG_OVERRIDE] |=>
    singleEndedMode == $past(ctrlReg[CTRL_CFG_SE]))
    else $error("Host mode setting not applied");

  a_shutdown_pin: assert property (!pinS.shutdownN |=>
    !ampEnable)
    else $error("Shutdown pin did not stop the amplifier");

  a_bus_in_shutdown: assert property (!ampEnable && startSeen |=>
    state == S_ADDR)
    else $error("Serial bus not alive during shutdown");

  a_beep_enable: assert property (
    (pinS.beepInput || pinS.beepModeEnable || ctrlReg[CTRL_BEEP_ENABLE])
    |=> beepActive)
    else $error("Beep mode not entered");

  a_addr_ack: assert property (
    $rose(state == S_ACK_ADR) |-> sdaOe
      && $past(shift[2:1]) == $past({pinS.slaveAddrPinBit1,
                                     pinS.slaveAddrPinBit0}))
    else $error("Acknowledged an address with other pin bits");

  a_neg_out_hiz: assert property (1'b1 |=>
    leftNegativeOutOe == !$past(ctrlReg[CTRL_CFG_OVERRIDE]
      ? ctrlReg[CTRL_CFG_SE] : pinS.outputConfigSelect)
      && rightNegativeOutOe == leftNegativeOutOe)
    else $error("Negative output enable does not follow mode");

  a_chan_select: assert property (singleEndedMode |->
    leftChan == $past(gainReg[IDX_LEFT_SINGLE_ENDED_GAIN[1:0]])
      && rightChan == $past(gainReg[IDX_RIGHT_SINGLE_ENDED_GAIN[1:0]]))
    else $error("Channel not taken from single-ended register");

  a_gain_write: assert property (byteWrittenLeftSe |=>
    gainReg[IDX_LEFT_SINGLE_ENDED_GAIN[1:0]] == $past(shift) ##1 state == S_ACK_WR)
    else $error("Gain register write lost");

  a_reset_gain: assert property (@(posedge clock) disable iff (1'b0)
    $rose(nrst) |-> gainReg[IDX_LEFT_BRIDGED[1:0]] == GAIN_RESET_BRIDGED
      && gainReg[IDX_LEFT_SINGLE_ENDED_GAIN[1:0]] == GAIN_RESET_SE)
    else $error("Gain register not at power-up value");

endmodule

// >>> testbench/agm_i2c_host.sv
// Purpose: Serial bus host model driving SCL and pulling SDA low
// Assumes: SDA has a pull-up; SCL stands high between frames
// Notes:   Bit period 125 ns, free of the system clock phase
`timescale 1ns/100ps
module agm_i2c_host (
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaPull
);
  // Quarter periods of two sizes so that each bit lasts exactly 125 ns
  localparam real QA = 31.2;
  localparam real QB = 31.3;
  // ==========================================================
  // Bus released at start
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // Start or repeated start, SDA falls with SCL high
  task automatic start();
    sdaPull = 1'b0;
    #QA scl = 1'b1;
    #QB sdaPull = 1'b1;
    #QA scl = 1'b0;
    #QB;
  endtask
  // Stop, SDA rises with SCL high
  task automatic stop();
    sdaPull = 1'b1;
    #QA scl = 1'b1;
    #QB sdaPull = 1'b0;
    #(QA + QB);
  endtask
  // One bit: SDA set in low phase, wire sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sdaPull = ~b;
    #QA scl = 1'b1;
    #QB r = sdaWire;
    #QA scl = 1'b0;
    #QB;
  endtask
  // Byte out MSB first, then the slave acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Byte in MSB first, then host ack or nack on the last
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// >>> testbench/tb.sv
// Purpose: Self-checking bench of the gain and mode control block
// Assumes: Host model on the serial pins, pins driven on clock edges
// Notes:   Expected values come from a register model in the bench
`timescale 1ns/100ps
module tb;
  import agm_pkg::*;
  logic        clock, nrst, sel, shutN, beepEn, beepIn, a1, a0;
  logic        hScl, hPull, sdaWire, devOut, devOe;
  logic        se, hp, amp, beep, lOe, rOe, ack;
  agm_chan_s   lChan, rChan;
  agm_pins_s   pins;
  logic [7:0]  wb [0:3];
  int          mreg [0:4];
  logic [15:0] rnd;
  int          num_errors, tests_run;

  // ==========================================================
  // Open-drain wire with pull-up, and pin bundle
  assign sdaWire = ~hPull & ~(devOe & ~devOut);
  assign pins = {hScl, sdaWire, sel, shutN, beepEn, beepIn, a1, a0};

  agm_i2c_host host (.sdaWire(sdaWire), .scl(hScl), .sdaPull(hPull));
  amp_gain_mode_control uut (
    .clock(clock), .nrst(nrst), .pins(pins),
    .sdaOut(devOut), .sdaOe(devOe), .singleEndedMode(se),
    .headphoneSelect(hp), .ampEnable(amp), .beepActive(beep),
    .leftNegativeOutOe(lOe), .rightNegativeOutOe(rOe),
    .leftChan(lChan), .rightChan(rChan));

  // ==========================================================
  // Model functions
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic exp_se();
    return mreg[4][0] ? mreg[4][1] : sel;
  endfunction
  function automatic logic exp_beep();
    return beepIn | beepEn | mreg[4][2];
  endfunction
  function automatic logic [7:0] exp_reg(input int p);
    if (p < 5) return mreg[p][7:0];
    if (p == 5) return {3'h0, a1, a0, ~shutN, exp_beep(), exp_se()};
    return 8'h00;
  endfunction
  function automatic logic [7:0] adr(input logic rd);
    return {SLAVE_ADDR_HIGH, a1, a0, rd};
  endfunction

  // ==========================================================
  // Compare, report and pin tasks
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic set_pins(input logic [3:0] v);
    @(posedge clock);
    {sel, shutN, beepEn, beepIn} <= v;
  endtask
  // All mode outputs against the model once the pins have settled
  task automatic check_all();
    logic s;
    repeat (8) @(posedge clock);
    @(negedge clock);
    s = exp_se();
    chk("mode", s, se);
    chk("input mux", s, hp);
    chk("neg oe", {~s, ~s}, {lOe, rOe});
    chk("left", s ? mreg[2][7:0] : mreg[0][7:0], lChan);
    chk("right", s ? mreg[3][7:0] : mreg[1][7:0], rChan);
    chk("amp", shutN, amp);
    chk("beep", exp_beep(), beep);
  endtask
  // Pointer write then data bytes, model follows
  task automatic wr_regs(input int p, input int n);
    host.start();
    host.wr_byte(adr(1'b0), ack);
    chk("addr ack", 8'h01, ack);
    host.wr_byte(p[7:0], ack);
    for (int i = 0; i < n; i++) begin
      host.wr_byte(wb[i], ack);
      chk("data ack", 8'h01, ack);
      if (p + i < 5) mreg[p + i] = wb[i];
    end
    host.stop();
  endtask
  // Pointer write, repeated start, burst read with auto-increment
  task automatic rd_regs(input int p, input int n);
    logic [7:0] d;
    host.start();
    host.wr_byte(adr(1'b0), ack);
    host.wr_byte(p[7:0], ack);
    host.start();
    host.wr_byte(adr(1'b1), ack);
    chk("read ack", 8'h01, ack);
    for (int i = 0; i < n; i++) begin
      host.rd_byte(i == n - 1, d);
      chk("reg read", exp_reg(p + i), d);
    end
    host.stop();
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    $display("[FAIL] run expected end seen timeout");
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    num_errors = 0;
    tests_run = 0;
    nrst = 1'b0;
    {sel, shutN, beepEn, beepIn, a1, a0} = 6'h00;
    mreg[0] = GAIN_RESET_BRIDGED;
    mreg[1] = GAIN_RESET_BRIDGED;
    mreg[2] = GAIN_RESET_SE;
    mreg[3] = GAIN_RESET_SE;
    mreg[4] = CTRL_RESET;
    rnd = 16'h78d9;
    // Outputs stand at their reset levels while reset is held
    repeat (9) @(posedge clock);
    @(negedge clock);
    chk("reset left", GAIN_RESET_BRIDGED, lChan);
    chk("reset right", GAIN_RESET_BRIDGED, rChan);
    chk("reset outs", 8'h00, {devOe, se, hp, amp, beep, lOe, rOe});
    @(posedge clock);
    nrst <= 1'b1;
    {a1, a0} <= rnd[1:0];
    set_pins(4'b0100);
    check_all();
    set_pins(4'b1100);
    check_all();
    rd_regs(0, 7);
    // Each address pin pair: own address acked, other refused
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      {a1, a0} <= k[1:0];
      repeat (8) @(posedge clock);
      host.start();
      host.wr_byte({SLAVE_ADDR_HIGH, ~k[1:0], 1'b0}, ack);
      chk("wrong addr", 8'h00, ack);
      host.stop();
      rd_regs(5, 1);
    end
    // Random gains and mutes into all four registers
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wb[i] = rnd[7:0];
    end
    wr_regs(0, 4);
    rd_regs(0, 4);
    // Top code with both mutes, then run into read-only and unmapped
    wb[0] = 8'hff;
    wb[1] = 8'h00;
    wb[2] = 8'h5a;
    wr_regs(3, 3);
    rd_regs(3, 4);
    // Select pin against override bits
    for (int m = 0; m < 8; m++) begin
      wb[0] = {6'h00, m[2:1]};
      wr_regs(4, 1);
      set_pins({m[0], 3'b100});
      check_all();
    end
    // Beep sources with shutdown; bus stays alive in shutdown
    for (int k = 0; k < 8; k++) begin
      wb[0] = {5'h00, k[2], 2'b00};
      wr_regs(4, 1);
      set_pins({1'b0, k[0] ^ k[1], k[1:0]});
      check_all();
      rd_regs(5, 1);
    end
    tally_and_finish();
  end
endmodule
